// ---- rtl/eprom_programmer.sv ----
// Purpose: Host controller driving an EPROM parallel programming port
// Assumes: Software issues one command at a time and polls busy
// Notes:   Data port is tri-stated by enable; low enable means driving
// Notes on behaviour
// RULE_01: Keep device oscillator running at 4-6 MHz.
// RULE_02: Address on port 1 and port 2 low bits.
// RULE_03: Drive code byte on port 0 when programming.
// RULE_04: Low strobe pulse programs the presented byte.
// RULE_05: Supply high, raise to programming, strobe, lower.
// RULE_06: Verify only after supply back at high.
// RULE_07: Code programming select pattern applied.
// RULE_08: Verify and signature select patterns applied.
// RULE_09: Encryption and lock-bit select patterns applied.
// RULE_10: Address, data, selects, supply, then strobes.
// RULE_11: Five strobes main byte, 25 otherwise.
// RULE_12: Repeat steps per byte until image written.
// RULE_13: Lock bits have no direct read-back.
// RULE_14: Verify returns XNOR with encryption byte.
// RULE_15: First lock bit blocks further programming.
// RULE_16: Erased cells read as ones.
// RULE_17: Verify written byte, flag any mismatch.
//
// The implementer's own choices: the register addresses and the plain strobed port.
module eprom_programmer
  import eprom_prog_pkg::*;
#(
  parameter int unsigned OSC_DIVIDE  = OSC_DIV,
  parameter int unsigned SETUP_CYCS  = SETUP_CYC,
  parameter int unsigned VPP_CYCS    = VPP_SETUP_CYC,
  parameter int unsigned GAP_CYCS    = GAP_CYC,
  parameter int unsigned PULSE_CYCS  = PULSE_CYC
)(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // Software register port
  input  wire logic [3:0]  sw_addr,
  input  wire logic [15:0] sw_wdata,
  input  wire logic        sw_wr,
  input  wire logic        sw_rd,
  output logic      [15:0] sw_rdata,
  // Device oscillator and control pins
  output logic             osc_clk,
  output pins_t            dev_pins,
  // Device data port 0
  input  wire logic [7:0]  data_in,
  output logic      [7:0]  data_out,
  output logic             data_oe_n
);

  // States, Gray coded along the program path
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_SETUP = 3'b001,
    S_VPPUP = 3'b011,
    S_PULSE = 3'b010,
    S_GAP   = 3'b110,
    S_VPPDN = 3'b111,
    S_READ  = 3'b101
  } state_t;

  logic        rst_s1_ff;          // Reset synchroniser stage 1
  logic        rst_ff;             // Synchronised reset, active low
  logic [14:0] addr_ff;            // Target address
  logic [7:0]  wdata_ff;           // Byte to write
  op_t         op_ff;              // Current operation
  logic        chk_ff;             // Verify after program
  state_t      state_ff;           // Sequencer state
  logic [31:0] cnt_ff;             // Interval counter
  logic [4:0]  strobes_ff;         // Strobes remaining
  logic        done_ff;            // Sticky completion
  logic        mism_ff;            // Sticky mismatch
  logic [7:0]  rdata_ff;           // Last byte read back
  logic [7:0]  osc_cnt_ff;         // Oscillator divider
  logic        osc_ff;             // Oscillator output
  logic        start;              // Command write
  logic        busy;               // Sequencer active
  logic        is_read;            // Operation is a read

  assign start   = sw_wr && sw_addr == REG_CMD && state_ff == S_IDLE;
  assign busy    = state_ff != S_IDLE;
  assign is_read = op_ff == OP_VERIFY || op_ff == OP_SIGNATURE;

  // Reset release through two flops
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_s1_ff <= 1'b0;
      rst_ff    <= 1'b0;
    end
    else
    begin
      rst_s1_ff <= 1'b1;
      rst_ff    <= rst_s1_ff;
    end
  end

  // Device oscillator divider, kept running
  always_ff @(posedge mclk or negedge rst_ff)
  begin
    if (!rst_ff)
    begin
      osc_cnt_ff <= 8'h00;
      osc_ff     <= 1'b0;
    end
    else if (osc_cnt_ff == 8'((OSC_DIVIDE / 2) - 1))
    begin
      osc_cnt_ff <= 8'h00;
      osc_ff     <= ~osc_ff;                          // RULE_01
    end
    else
      osc_cnt_ff <= osc_cnt_ff + 8'h01;
  end
  assign osc_clk = osc_ff;

  // Software-written address, data and command
  always_ff @(posedge mclk or negedge rst_ff)
  begin
    if (!rst_ff)
    begin
      addr_ff  <= 15'h0000;
      wdata_ff <= 8'h00;
      op_ff    <= OP_VERIFY;
      chk_ff   <= 1'b0;
    end
    else if (sw_wr && !busy)
    begin
      if (sw_addr == REG_ADDR)
        addr_ff <= sw_wdata[14:0];                     // RULE_12
      else if (sw_addr == REG_DATA)
        wdata_ff <= sw_wdata[7:0];
      else if (sw_addr == REG_CMD)
      begin
        op_ff  <= op_t'(sw_wdata[2:0]);
        chk_ff <= sw_wdata[3];                         // RULE_17
      end
    end
    else if (state_ff == S_VPPDN && cnt_ff == 32'h0 && chk_ff)
    begin
      op_ff  <= OP_VERIFY;                             // RULE_17
      chk_ff <= 1'b0;
    end
  end

  // Program and read sequencer
  always_ff @(posedge mclk or negedge rst_ff)
  begin
    if (!rst_ff)
    begin
      state_ff   <= S_IDLE;
      cnt_ff     <= 32'h0;
      strobes_ff <= 5'h00;
    end
    else
    begin
      case (state_ff)
        S_IDLE:
          if (start)
          begin
            state_ff <= S_SETUP;                       // RULE_10
            cnt_ff   <= 32'(SETUP_CYCS);
          end
        S_SETUP:
          if (cnt_ff != 32'h0)
            cnt_ff <= cnt_ff - 32'h1;
          else if (is_read)
          begin
            state_ff <= S_READ;                        // RULE_06
            cnt_ff   <= 32'(SETUP_CYCS);
          end
          else
          begin
            state_ff   <= S_VPPUP;                     // RULE_05
            cnt_ff     <= 32'(VPP_CYCS);
            strobes_ff <= (op_ff == OP_PROG_CODE) ?
                          5'(STROBES_MAIN) : 5'(STROBES_LONG); // RULE_11
          end
        S_VPPUP:
          if (cnt_ff != 32'h0)
            cnt_ff <= cnt_ff - 32'h1;
          else
          begin
            state_ff <= S_PULSE;                       // RULE_04
            cnt_ff   <= 32'(PULSE_CYCS);
          end
        S_PULSE:
          if (cnt_ff != 32'h0)
            cnt_ff <= cnt_ff - 32'h1;
          else
          begin
            state_ff   <= S_GAP;
            cnt_ff     <= 32'(GAP_CYCS);
            strobes_ff <= strobes_ff - 5'h01;
          end
        S_GAP:
          if (cnt_ff != 32'h0)
            cnt_ff <= cnt_ff - 32'h1;
          else if (strobes_ff != 5'h00)
          begin
            state_ff <= S_PULSE;                       // RULE_11
            cnt_ff   <= 32'(PULSE_CYCS);
          end
          else
          begin
            state_ff <= S_VPPDN;                       // RULE_05
            cnt_ff   <= 32'(SETUP_CYCS);
          end
        S_VPPDN:
          if (cnt_ff != 32'h0)
            cnt_ff <= cnt_ff - 32'h1;
          else if (chk_ff)
          begin
            state_ff <= S_SETUP;                       // RULE_06
            cnt_ff   <= 32'(SETUP_CYCS);
          end
          else
            state_ff <= S_IDLE;
        S_READ:
          if (cnt_ff != 32'h0)
            cnt_ff <= cnt_ff - 32'h1;
          else
            state_ff <= S_IDLE;
        default:
          state_ff <= S_IDLE;
      endcase
    end
  end

  // Read-back capture, completion and mismatch flags
  always_ff @(posedge mclk or negedge rst_ff)
  begin
    if (!rst_ff)
    begin
      rdata_ff <= 8'h00;
      done_ff  <= 1'b0;
      mism_ff  <= 1'b0;
    end
    else
    begin
      // Set wins over a clear in the same cycle
      if (state_ff == S_READ && cnt_ff == 32'h0)
      begin
        rdata_ff <= data_in;
        done_ff  <= 1'b1;
        if (op_ff == OP_VERIFY && data_in != wdata_ff)
          mism_ff <= 1'b1;                             // RULE_17
        else if (sw_wr && sw_addr == REG_STATUS && sw_wdata[ST_MISMATCH])
          mism_ff <= 1'b0;
      end
      else if (state_ff == S_VPPDN && cnt_ff == 32'h0 && !chk_ff)
      begin
        done_ff <= 1'b1;
        // Mismatch clear still honoured while done is being set
        if (sw_wr && sw_addr == REG_STATUS && sw_wdata[ST_MISMATCH])
          mism_ff <= 1'b0;
      end
      else if (start)
        done_ff <= 1'b0;
      else if (sw_wr && sw_addr == REG_STATUS)
      begin
        if (sw_wdata[ST_DONE])
          done_ff <= 1'b0;
        if (sw_wdata[ST_MISMATCH])
          mism_ff <= 1'b0;
      end
    end
  end

  // Pin drive: selects per mode, supply and strobe per state
  always_ff @(posedge mclk or negedge rst_ff)
  begin
    if (!rst_ff)
    begin
      dev_pins  <= '0;
      data_out  <= 8'h00;
      data_oe_n <= 1'b1;
    end
    else
    begin
      dev_pins.addr       <= addr_ff;                  // RULE_02
      dev_pins.rst        <= busy;
      dev_pins.store_en_n <= 1'b0;
      dev_pins.strobe_n   <= state_ff != S_PULSE;      // RULE_04
      dev_pins.vpp_on     <= state_ff == S_VPPUP ||
                             state_ff == S_PULSE ||
                             state_ff == S_GAP;        // RULE_05
      dev_pins.vpp_high   <= busy;
      data_out            <= wdata_ff;                 // RULE_03
      data_oe_n           <= !(busy && !is_read);
      case (op_ff)
        OP_PROG_CODE: dev_pins.sel <= SEL_PROG_CODE;   // RULE_07
        OP_PROG_KEY:  dev_pins.sel <= SEL_PROG_KEY;    // RULE_09
        OP_LOCK_ONE:  dev_pins.sel <= SEL_LOCK_ONE;    // RULE_09
        OP_LOCK_TWO:  dev_pins.sel <= SEL_LOCK_TWO;    // RULE_09
        OP_LOCK_THR:  dev_pins.sel <= SEL_LOCK_THR;    // RULE_09
        OP_SIGNATURE: dev_pins.sel <= SEL_SIGNATURE;   // RULE_08
        default:      dev_pins.sel <= SEL_VERIFY;      // RULE_08
      endcase
    end
  end

  // Register read data, one cycle after the strobe
  always_ff @(posedge mclk or negedge rst_ff)
  begin
    if (!rst_ff)
      sw_rdata <= 16'h0000;
    else if (sw_rd)
    begin
      if (sw_addr == REG_ADDR)
        sw_rdata <= {1'b0, addr_ff};
      else if (sw_addr == REG_DATA)
        sw_rdata <= {8'h00, wdata_ff};
      else if (sw_addr == REG_CMD)
        sw_rdata <= {12'h000, chk_ff, op_ff};
      else if (sw_addr == REG_STATUS)
        sw_rdata <= {13'h0, mism_ff, done_ff, busy};
      else if (sw_addr == REG_RDATA)
        sw_rdata <= {8'h00, rdata_ff};
      else
        sw_rdata <= 16'h0000;
    end
    else
      sw_rdata <= 16'h0000;
  end

endmodule : eprom_programmer

// ---- rtl/eprom_prog_pkg.sv ----
// Purpose: Shared constants and types for the EPROM programmer controller
// Assumes: Controller clock mclk at 250 MHz
// Notes:   Command, mode and pin-select encodings live here
package eprom_prog_pkg;

  // Clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS  = 4000;
  // Device oscillator window, kHz (4 to 6 MHz)
  localparam int unsigned OSC_MIN_KHZ    = 4000;
  localparam int unsigned OSC_MAX_KHZ    = 6000;
  // Default oscillator divider: 250 MHz / 50 = 5 MHz
  localparam int unsigned OSC_DIV        = 50;
  // Setup/hold before and after strobe: 48 oscillator periods
  localparam int unsigned SETUP_TCLCL    = 48;
  localparam int unsigned SETUP_CYC      = SETUP_TCLCL * OSC_DIV;
  // Supply setup/hold, strobe gap, microseconds
  localparam int unsigned VPP_SETUP_US   = 10;
  localparam int unsigned VPP_SETUP_CYC  =
    (VPP_SETUP_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned GAP_US         = 10;
  localparam int unsigned GAP_CYC        =
    (GAP_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Strobe width 90 to 110 us; aim at the middle, 100 us
  localparam int unsigned PULSE_US       = 100;
  localparam int unsigned PULSE_CYC      =
    (PULSE_US * 1000000) / CLK_PERIOD_PS;
  // Strobe counts per step
  localparam int unsigned STROBES_MAIN   = 5;
  localparam int unsigned STROBES_LONG   = 25;

  // Software register offsets
  localparam logic [3:0] REG_ADDR        = 4'h0;
  localparam logic [3:0] REG_DATA        = 4'h1;
  localparam logic [3:0] REG_CMD         = 4'h2;
  localparam logic [3:0] REG_STATUS      = 4'h3;
  localparam logic [3:0] REG_RDATA       = 4'h4;
  // Status field positions
  localparam int unsigned ST_BUSY        = 0;
  localparam int unsigned ST_DONE        = 1;
  localparam int unsigned ST_MISMATCH    = 2;

  // Operations requested through the command register
  typedef enum logic [2:0] {
    OP_PROG_CODE = 3'h0,
    OP_PROG_KEY  = 3'h1,
    OP_LOCK_ONE  = 3'h2,
    OP_LOCK_TWO  = 3'h3,
    OP_LOCK_THR  = 3'h4,
    OP_VERIFY    = 3'h5,
    OP_SIGNATURE = 3'h6
  } op_t;

  // Mode-select pin levels
  typedef struct packed {
    logic p2_6;
    logic p2_7;
    logic p3_3;
    logic p3_6;
    logic p3_7;
  } sel_t;

  // Pin-level selects per mode
  localparam sel_t SEL_PROG_CODE = 5'h0F;  // L H H H H
  localparam sel_t SEL_PROG_KEY  = 5'h0D;  // L H H L H
  localparam sel_t SEL_LOCK_ONE  = 5'h1F;  // H H H H H
  localparam sel_t SEL_LOCK_TWO  = 5'h1C;  // H H H L L
  localparam sel_t SEL_LOCK_THR  = 5'h16;  // H L H H L
  localparam sel_t SEL_VERIFY    = 5'h03;  // L L L H H
  localparam sel_t SEL_SIGNATURE = 5'h00;  // L L L L L

  // Device-facing pin group
  typedef struct packed {
    logic [14:0] addr;     // Port 1 in [7:0], port 2 bits 0..4 in [12:8]
    logic        rst;
    logic        store_en_n;
    logic        strobe_n;
    logic        vpp_on;
    logic        vpp_high;
    sel_t        sel;
  } pins_t;

endpackage : eprom_prog_pkg

// ---- verif/eprom_prog_asserts.sv ----
// Purpose: Port-level timing checks for the EPROM programmer
// Assumes: Bound to eprom_programmer; single clock mclk
// Notes:   Pulse and divider figures follow the bound parameters
module eprom_prog_asserts
  import eprom_prog_pkg::*;
#(
  parameter int unsigned OSC_DIVIDE = OSC_DIV,
  parameter int unsigned PULSE_CYCS = PULSE_CYC
)(
  // Clock and reset
  input wire logic       mclk,
  input wire logic       reset_n,
  // Observed outputs
  input wire logic       osc_clk,
  input wire pins_t      dev_pins,
  input wire logic [7:0] data_out,
  input wire logic       data_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic [15:0] low_ff;   // Cycles of the current low strobe
  logic [15:0] osc_ff;   // Cycles since last oscillator rise, 0 before one
  logic [5:0]  cnt_ff;   // Strobes in this supply window
  logic        osc_q_ff; // Oscillator one cycle ago
  logic        str_q_ff; // Strobe one cycle ago
  logic        prog_sel; // A programming pattern is on the selects
  assign prog_sel = dev_pins.sel == SEL_PROG_CODE
    || dev_pins.sel == SEL_PROG_KEY || dev_pins.sel == SEL_LOCK_ONE
    || dev_pins.sel == SEL_LOCK_TWO || dev_pins.sel == SEL_LOCK_THR;
  // Width, divider and strobe counters
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
    begin
      low_ff   <= '0;
      osc_ff   <= '0;
      cnt_ff   <= '0;
      osc_q_ff <= 1'b0;
      str_q_ff <= 1'b0;
    end
    else
    begin
      low_ff   <= (!dev_pins.strobe_n && dev_pins.vpp_on) ? low_ff + 16'h1
                                                          : 16'h0;
      osc_ff   <= (osc_clk && !osc_q_ff) ? 16'h1 :
                  (osc_ff != 16'h0) ? osc_ff + 16'h1 : 16'h0;
      cnt_ff   <= !dev_pins.vpp_on ? 6'h0 :
                  (str_q_ff && !dev_pins.strobe_n) ? cnt_ff + 6'h1 : cnt_ff;
      osc_q_ff <= osc_clk;
      str_q_ff <= dev_pins.strobe_n;
    end
  sequence s_held;
    (!data_oe_n && $stable(dev_pins.addr) && $stable(data_out)) [*4];
  endsequence
  property p_vpp_strobe;
    $fell(dev_pins.strobe_n) |-> dev_pins.vpp_on && dev_pins.rst
      && !dev_pins.store_en_n;
  endproperty
  property p_strobe_sel;
    $fell(dev_pins.strobe_n) |-> prog_sel;
  endproperty
  property p_held;
    $fell(dev_pins.strobe_n) |-> !data_oe_n ##1 s_held;
  endproperty
  property p_vpp_setup;
    $fell(dev_pins.strobe_n) |-> $past(dev_pins.vpp_on, 3);
  endproperty
  property p_width;
    $rose(dev_pins.strobe_n) && dev_pins.vpp_on
      |-> low_ff == 16'(PULSE_CYCS + 1);
  endproperty
  property p_count;
    $fell(dev_pins.vpp_on)
      |-> cnt_ff == ((dev_pins.sel == SEL_PROG_CODE) ? 6'(STROBES_MAIN)
                                                     : 6'(STROBES_LONG));
  endproperty
  property p_read_mode;
    dev_pins.rst && (dev_pins.sel == SEL_VERIFY
      || dev_pins.sel == SEL_SIGNATURE) |-> data_oe_n && dev_pins.strobe_n
      && !dev_pins.vpp_on && dev_pins.vpp_high;
  endproperty
  property p_osc;
    osc_clk && !osc_q_ff && osc_ff != 16'h0 |-> osc_ff == 16'(OSC_DIVIDE);
  endproperty
  a_vpp_strobe: assert property (p_vpp_strobe)
    else $error("strobe without supply or device reset");
  a_strobe_sel: assert property (p_strobe_sel)
    else $error("strobe under a non-programming select");
  a_held: assert property (p_held)
    else $error("address or data moved during strobe");
  a_vpp_setup: assert property (p_vpp_setup)
    else $error("supply raised too late before strobe");
  a_width: assert property (p_width)
    else $error("strobe width wrong");
  a_count: assert property (p_count)
    else $error("wrong strobe count in supply window");
  a_read_mode: assert property (p_read_mode)
    else $error("read mode with strobe, supply or drive active");
  a_osc: assert property (p_osc)
    else $error("oscillator period wrong");
endmodule : eprom_prog_asserts

bind eprom_programmer eprom_prog_asserts #(
  .OSC_DIVIDE (OSC_DIVIDE),
  .PULSE_CYCS (PULSE_CYCS)
) u_asserts (
  .mclk      (mclk),
  .reset_n   (reset_n),
  .osc_clk   (osc_clk),
  .dev_pins  (dev_pins),
  .data_out  (data_out),
  .data_oe_n (data_oe_n)
);

// ---- verif/eprom_dev_model.sv ----
// Purpose: Behavioural model of the device's programming port
// Assumes: Programs at the end of each strobe pulse
// Notes:   Read data show only after RD_LAG settled cycles
module eprom_dev_model
  import eprom_prog_pkg::*;
#(
  parameter logic [7:0]  SIG_BYTE = 8'hA5, // Arbitrary signature value
  parameter int unsigned RD_LAG   = 2      // Settle time before read data
)(
  input wire logic       mclk,
  input wire pins_t      dev_pins,
  input wire logic [7:0] data_out,
  input wire logic       data_oe_n,
  output logic     [7:0] data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:8191]; // Code array
  logic [7:0] key [0:63];   // Encryption array
  logic       locked;       // First lock bit programmed
  logic       str_q;        // Strobe one cycle ago
  logic [7:0] flt;          // Changing pattern on an idle port
  logic [7:0] stab;         // Cycles with unchanged address and selects
  pins_t      pins_q;       // Pins one cycle ago
  logic [7:0] pbyte;        // Byte taken from port 0
  initial
  begin
    for (int i = 0; i < 8192; i++) mem[i] = 8'hFF;
    for (int i = 0; i < 64; i++) key[i] = 8'hFF;
    locked = 1'b0;
    str_q = 1'b1;
    flt = 8'h00;
    stab = 8'h00;
  end
  assign pbyte = data_oe_n ? 8'hFF : data_out;
  // Program on the rising end of a strobe under supply
  always @(posedge mclk)
  begin
    str_q <= dev_pins.strobe_n;
    pins_q <= dev_pins;
    flt <= flt + 8'h01;
    stab <= (dev_pins.addr == pins_q.addr && dev_pins.sel == pins_q.sel)
            ? stab + {7'h0, stab != 8'hFF} : 8'h00;
    if (dev_pins.strobe_n && !str_q && dev_pins.vpp_on && dev_pins.rst
        && !locked)
    begin
      if (dev_pins.sel == SEL_PROG_CODE)
        mem[dev_pins.addr[12:0]] <= mem[dev_pins.addr[12:0]] & pbyte;
      if (dev_pins.sel == SEL_PROG_KEY)
        key[dev_pins.addr[5:0]] <= key[dev_pins.addr[5:0]] & pbyte;
      if (dev_pins.sel == SEL_LOCK_ONE)
        locked <= 1'b1;
    end
  end
  // Read path; lock bits have no read path at all
  always_comb
    if (!dev_pins.rst || !dev_pins.strobe_n || dev_pins.vpp_on
        || stab < 8'(RD_LAG))
      data_in = flt;
    else if (dev_pins.sel == SEL_VERIFY)
      data_in = ~(mem[dev_pins.addr[12:0]] ^ key[dev_pins.addr[5:0]]);
    else if (dev_pins.sel == SEL_SIGNATURE)
      data_in = SIG_BYTE;
    else
      data_in = flt;
endmodule : eprom_dev_model

// ---- verif/testbench.sv ----
// Purpose: Self-checking bench for the EPROM programmer
// Assumes: Shortened timing parameters
// Notes:   Reset-state check first, then table rows, then a reset mid-command
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import eprom_prog_pkg::*;
  typedef struct packed {
    logic [3:0] cmd; logic [15:0] adr; logic [7:0] dat;
    logic [7:0] exp; logic mis; logic rd;
  } row_t;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic [3:0]  sw_addr = 4'h0;
  logic [15:0] sw_wdata = 16'h0000;
  logic        sw_wr = 1'b0;
  logic        sw_rd = 1'b0;
  logic [15:0] sw_rdata;
  pins_t       dev_pins;
  logic [7:0]  data_in;
  logic [7:0]  data_out;
  logic        data_oe_n;
  int          err_total = 0;
  int          n_tests = 0;
  logic [15:0] d;
  row_t        rows [11] = '{
    '{4'h8, 16'h0123, 8'h5A, 8'h5A, 1'b0, 1'b1},
    '{4'h8, 16'h1FFF, 8'h00, 8'h00, 1'b0, 1'b1},
    '{4'h1, 16'h0005, 8'hF0, 8'h00, 1'b0, 1'b0},
    '{4'h5, 16'h0005, 8'hF0, 8'hF0, 1'b0, 1'b1},
    '{4'h5, 16'h0045, 8'hF0, 8'hF0, 1'b0, 1'b1},
    '{4'h5, 16'h0777, 8'hFF, 8'hFF, 1'b0, 1'b1},
    '{4'h6, 16'h0030, 8'h00, 8'hA5, 1'b0, 1'b1},
    '{4'h3, 16'h0000, 8'h00, 8'h00, 1'b0, 1'b0},
    '{4'h4, 16'h0000, 8'h00, 8'h00, 1'b0, 1'b0},
    '{4'h2, 16'h0000, 8'h00, 8'h00, 1'b0, 1'b0},
    '{4'h8, 16'h0200, 8'h11, 8'hFF, 1'b1, 1'b1}
  };
  always #2 mclk = ~mclk;
  eprom_programmer #(.OSC_DIVIDE(4), .SETUP_CYCS(4), .VPP_CYCS(3),
    .GAP_CYCS(3), .PULSE_CYCS(5)) dut (.mclk(mclk), .reset_n(reset_n),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata), .osc_clk(), .dev_pins(dev_pins),
    .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n));
  eprom_dev_model u_dev (.mclk(mclk),
    .dev_pins(dev_pins), .data_out(data_out), .data_oe_n(data_oe_n),
    .data_in(data_in));
  task give_verdict;
    if (err_total == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge mclk);
    sw_addr <= a;
    sw_wdata <= v;
    sw_wr <= 1'b1;
    @(posedge mclk);
    sw_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge mclk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge mclk);
    sw_rd <= 1'b0;
    #1 v = sw_rdata;
  endtask : rd
  task run_row(input row_t r);
    int n;
    wr(REG_ADDR, r.adr);
    wr(REG_DATA, {8'h00, r.dat});
    wr(REG_CMD, {12'h000, r.cmd});
    wr(REG_DATA, {8'h00, ~r.dat}); // Ignored while busy
    n = 0;
    d = 16'h0001;
    while (d[ST_BUSY] !== 1'b0 && n < 3000)
    begin
      rd(REG_STATUS, d);
      n++;
    end
    if (n >= 3000)
    begin
      err_total++;
      give_verdict();
    end
    chk(d[2:0], {r.mis, 2'b10});
    if (r.rd)
    begin
      rd(REG_RDATA, d);
      chk(d, {8'h00, r.exp});
    end
    wr(REG_STATUS, 16'h0006);
  endtask : run_row
  initial
  begin
    repeat (20) @(posedge mclk);
    chk({dev_pins, data_oe_n}, 32'h1);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(4'hF, d);
    chk(d, 32'h0);
    foreach (rows[i]) run_row(rows[i]);
    rd(REG_STATUS, d);
    chk(d, 32'h0);
    wr(REG_ADDR, 16'h0300);
    wr(REG_CMD, 16'h0000);
    repeat (30) @(posedge mclk);
    reset_n <= 1'b0;
    #1 chk({dev_pins, data_oe_n}, 32'h1);
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(REG_STATUS, d);
    chk(d, 32'h0);
    give_verdict();
  end
endmodule : testbench
